// ==== rtl/dhbp_dev.sv ====
// Device end: parallel and serial host port
`timescale 1ns/1ps
`default_nettype none
`include "dhbp_params.svh"
module dhbp_dev (
    input wire logic CLK,
    input wire logic RST_B,
    dhbp_if.dev BUS,
    input wire logic [7:0] RD_DATA,
    output logic WR_VALID,
    output logic [7:0] WR_BYTE,
    output logic WR_IS_DATA,
    output logic RD_TAKEN,
    output logic RD_IS_DATA,
    output logic [1:0] STYLE,
    output logic CHIP_RESET
);
    logic rst_q;
    logic pin_rst_b;
    dhbp_pkg::dhbp_style_e style_q;
    logic style_ok_q;
    logic en_q, dir_q, sck_q;
    logic reading_q;
    logic [7:0] dout_q;
    logic [7:0] shift_q;
    logic [2:0] cnt_q;
    logic sel;
    logic en_rise, rd_fall, wr_fall, sck_rise;
    assign pin_rst_b = RST_B & BUS.reset_input_low;
    assign sel = ~BUS.unit_select_low;
    assign en_rise = BUS.enable_or_read_strobe & ~en_q;
    assign rd_fall = ~BUS.enable_or_read_strobe & en_q;
    assign wr_fall = ~BUS.direction_or_write_strobe & dir_q;
    assign sck_rise = BUS.host_data_bus[`DHBP_SCK_BIT] & ~sck_q;
    // Strap taken once, first clock after release
    always_ff @(posedge CLK or negedge pin_rst_b) begin
        if (!pin_rst_b) begin
            style_q <= dhbp_pkg::DHBP_ENABLE;
            style_ok_q <= 1'b0;
        end else if (!style_ok_q) begin
            style_ok_q <= 1'b1;
            case ({BUS.protocol_select_b, BUS.protocol_select_a})
                `DHBP_SEL_ENABLE: style_q <= dhbp_pkg::DHBP_ENABLE;
                `DHBP_SEL_STROBE: style_q <= dhbp_pkg::DHBP_STROBE;
                default: style_q <= dhbp_pkg::DHBP_SERIAL;
            endcase
        end
    end
    always_ff @(posedge CLK or negedge pin_rst_b) begin
        if (!pin_rst_b) begin
            en_q <= 1'b0;
            dir_q <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            en_q <= BUS.enable_or_read_strobe;
            dir_q <= BUS.direction_or_write_strobe;
            sck_q <= BUS.host_data_bus[`DHBP_SCK_BIT];
        end
    end
    // Parallel and serial transfers and parallel read drive
    always_ff @(posedge CLK or negedge pin_rst_b) begin
        if (!pin_rst_b) begin
            WR_VALID <= 1'b0;
            WR_BYTE <= `DHBP_BYTE_ZERO;
            WR_IS_DATA <= 1'b0;
            RD_TAKEN <= 1'b0;
            RD_IS_DATA <= 1'b0;
            reading_q <= 1'b0;
            dout_q <= `DHBP_BYTE_ZERO;
            shift_q <= `DHBP_BYTE_ZERO;
            cnt_q <= `DHBP_CNT_ZERO;
        end else begin
            WR_VALID <= 1'b0;
            RD_TAKEN <= 1'b0;
            if (!style_ok_q || !sel) begin
                reading_q <= 1'b0;
                cnt_q <= `DHBP_CNT_ZERO;
            end else begin
                case (style_q)
                    dhbp_pkg::DHBP_ENABLE: begin
                        if (en_rise && BUS.direction_or_write_strobe) begin
                            reading_q <= 1'b1;
                            dout_q <= RD_DATA;
                            RD_TAKEN <= 1'b1;
                            RD_IS_DATA <= BUS.data_command_select;
                        end else if (en_rise) begin
                            WR_VALID <= 1'b1;
                            WR_BYTE <= BUS.host_data_bus;
                            WR_IS_DATA <= BUS.data_command_select;
                        end
                        if (!BUS.enable_or_read_strobe) begin
                            reading_q <= 1'b0;
                        end
                    end
                    dhbp_pkg::DHBP_STROBE: begin
                        if (rd_fall) begin
                            reading_q <= 1'b1;
                            dout_q <= RD_DATA;
                            RD_TAKEN <= 1'b1;
                            RD_IS_DATA <= BUS.data_command_select;
                        end else if (BUS.enable_or_read_strobe) begin
                            reading_q <= 1'b0;
                        end
                        // Sampled at the falling strobe; host holds data across it
                        if (wr_fall) begin
                            WR_VALID <= 1'b1;
                            WR_BYTE <= BUS.host_data_bus;
                            WR_IS_DATA <= BUS.data_command_select;
                        end
                    end
                    default: begin
                        reading_q <= 1'b0;
                        if (sck_rise) begin
                            shift_q <= {shift_q[6:0], BUS.host_data_bus[`DHBP_SDI_BIT]};
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == `DHBP_CNT_LAST) begin
                                WR_VALID <= 1'b1;
                                WR_BYTE <= {shift_q[6:0], BUS.host_data_bus[`DHBP_SDI_BIT]};
                                WR_IS_DATA <= BUS.data_command_select;
                            end
                        end
                    end
                endcase
            end
        end
    end
    always_ff @(posedge CLK or negedge pin_rst_b) begin
        if (!pin_rst_b) begin
            BUS.dev_data_out <= `DHBP_BYTE_ZERO;
            BUS.dev_data_oe <= 1'b0;
            STYLE <= 2'h0;
            CHIP_RESET <= 1'b1;
        end else begin
            BUS.dev_data_out <= dout_q;
            BUS.dev_data_oe <= reading_q & sel;
            STYLE <= style_q;
            CHIP_RESET <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/dhbp_host.sv ====
// Host end: drives one byte transfer per request
`timescale 1ns/1ps
`default_nettype none
`include "dhbp_params.svh"
module dhbp_host (
    input wire logic CLK,
    input wire logic RST_B,
    dhbp_if.host BUS,
    input wire logic [1:0] MODE,
    input wire logic REQ,
    input wire logic REQ_READ,
    input wire logic REQ_IS_DATA,
    input wire logic REQ_3WIRE,
    input wire logic [7:0] REQ_BYTE,
    output logic BUSY,
    output logic DONE,
    output logic [7:0] RD_BYTE
);
    dhbp_pkg::dhbp_hstate_e st_q;
    logic [3:0] hold_q;
    logic [2:0] bit_q;
    logic phase_q;
    logic rd_q, serial_q;
    logic [7:0] byte_q;
    // Straps follow MODE through reset so the device sees them settled at release
    always_ff @(posedge CLK) begin
        BUS.protocol_select_a <= MODE[0];
        BUS.protocol_select_b <= MODE[1];
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q <= dhbp_pkg::DHBP_IDLE;
            hold_q <= `DHBP_HOLD_ZERO;
            bit_q <= `DHBP_CNT_ZERO;
            phase_q <= 1'b0;
            rd_q <= 1'b0;
            serial_q <= 1'b0;
            byte_q <= `DHBP_BYTE_ZERO;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            RD_BYTE <= `DHBP_BYTE_ZERO;
            BUS.unit_select_low <= 1'b1;
            BUS.data_command_select <= 1'b0;
            BUS.enable_or_read_strobe <= 1'b0;
            BUS.direction_or_write_strobe <= 1'b0;
            BUS.reset_input_low <= 1'b1;
            BUS.host_data_out <= `DHBP_BYTE_ZERO;
            // D2 left free: style not known yet in reset
            BUS.host_data_oe <= 8'hFB;
        end else begin
            DONE <= 1'b0;
            case (st_q)
                dhbp_pkg::DHBP_IDLE: begin
                    // Idle strobe levels depend on style
                    BUS.enable_or_read_strobe <= (MODE == `DHBP_SEL_STROBE);
                    BUS.direction_or_write_strobe <= (MODE == `DHBP_SEL_STROBE);
                    BUS.host_data_oe <= MODE[1] ? 8'hFB : 8'hFF;
                    if (REQ) begin
                        st_q <= dhbp_pkg::DHBP_ACT;
                        BUSY <= 1'b1;
                        rd_q <= REQ_READ && MODE != 2'h2 && MODE != 2'h3;
                        serial_q <= MODE[1];
                        byte_q <= REQ_BYTE;
                        hold_q <= `DHBP_HOLD_CYC;
                        bit_q <= `DHBP_CNT_ZERO;
                        phase_q <= 1'b0;
                        BUS.unit_select_low <= 1'b0;
                        BUS.data_command_select <= REQ_IS_DATA & ~(MODE[1] & REQ_3WIRE);
                        BUS.host_data_out <= MODE[1] ? `DHBP_BYTE_ZERO : REQ_BYTE;
                        BUS.host_data_oe <= (REQ_READ && !MODE[1]) ? 8'h00 :
                            (MODE[1] ? 8'hFB : 8'hFF);
                        if (MODE == `DHBP_SEL_ENABLE) begin
                            BUS.direction_or_write_strobe <= REQ_READ;
                        end
                    end
                end
                dhbp_pkg::DHBP_ACT: begin
                    hold_q <= hold_q - 4'h1;
                    if (serial_q) begin
                        BUS.host_data_out[`DHBP_SDI_BIT] <= byte_q[7 - bit_q];
                        BUS.host_data_out[`DHBP_SCK_BIT] <= phase_q;
                        if (hold_q == `DHBP_HOLD_ZERO) begin
                            hold_q <= `DHBP_HOLD_CYC;
                            phase_q <= ~phase_q;
                            if (phase_q) begin
                                bit_q <= bit_q + 3'h1;
                                if (bit_q == `DHBP_CNT_LAST) begin
                                    st_q <= dhbp_pkg::DHBP_END;
                                end
                            end
                        end
                    end else begin
                        if (hold_q == `DHBP_HOLD_CYC) begin
                            BUS.enable_or_read_strobe <= (MODE == `DHBP_SEL_ENABLE) ? 1'b1 : ~rd_q;
                            if (MODE == `DHBP_SEL_STROBE) begin
                                BUS.direction_or_write_strobe <= rd_q;
                            end
                        end
                        if (hold_q == `DHBP_HOLD_ZERO) begin
                            RD_BYTE <= rd_q ? BUS.host_data_bus : RD_BYTE;
                            BUS.enable_or_read_strobe <= (MODE == `DHBP_SEL_STROBE);
                            BUS.direction_or_write_strobe <= (MODE == `DHBP_SEL_STROBE);
                            st_q <= dhbp_pkg::DHBP_END;
                        end
                    end
                end
                dhbp_pkg::DHBP_END: begin
                    BUS.unit_select_low <= 1'b1;
                    BUS.host_data_out <= `DHBP_BYTE_ZERO;
                    // After a read the device still drives one cycle; take the bus back later
                    if (!rd_q) begin
                        BUS.host_data_oe <= MODE[1] ? 8'hFB : 8'hFF;
                    end
                    BUSY <= 1'b0;
                    DONE <= 1'b1;
                    st_q <= dhbp_pkg::DHBP_IDLE;
                end
                default: st_q <= dhbp_pkg::DHBP_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== rtl/dhbp_if.sv ====
// Pin bundle between host and display port
`timescale 1ns/1ps
`default_nettype none
interface dhbp_if;
    logic unit_select_low;
    logic data_command_select;
    logic enable_or_read_strobe;
    logic direction_or_write_strobe;
    logic reset_input_low;
    logic protocol_select_a;
    logic protocol_select_b;
    logic [7:0] host_data_out;
    logic [7:0] host_data_oe;
    logic [7:0] dev_data_out;
    logic dev_data_oe;
    logic [7:0] host_data_bus;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (dev_data_oe) begin
                host_data_bus[i] = dev_data_out[i];
            end else if (host_data_oe[i]) begin
                host_data_bus[i] = host_data_out[i];
            end else begin
                host_data_bus[i] = 1'b0;
            end
        end
    end
    modport dev (
        input unit_select_low, data_command_select, enable_or_read_strobe,
        input direction_or_write_strobe, reset_input_low, protocol_select_a,
        input protocol_select_b, host_data_bus,
        output dev_data_out, dev_data_oe
    );
    modport host (
        output unit_select_low, data_command_select, enable_or_read_strobe,
        output direction_or_write_strobe, reset_input_low, protocol_select_a,
        output protocol_select_b, host_data_out, host_data_oe,
        input host_data_bus
    );
endinterface
`default_nettype wire

// ==== rtl/dhbp_params.svh ====
// Constants for the display host bus port
`ifndef DHBP_PARAMS_SVH
`define DHBP_PARAMS_SVH
`define DHBP_W 8
`define DHBP_SDI_BIT 1
`define DHBP_SCK_BIT 0
`define DHBP_D2_BIT 2
`define DHBP_BYTE_ZERO 8'h00
`define DHBP_CNT_LAST 3'h7
`define DHBP_CNT_ZERO 3'h0
`define DHBP_HOLD_CYC 4'h4
`define DHBP_HOLD_ZERO 4'h0
`define DHBP_SEL_ENABLE 2'h0
`define DHBP_SEL_STROBE 2'h1
`endif

// ==== rtl/dhbp_pkg.sv ====
// Types for the display host bus port
package dhbp_pkg;
    typedef enum logic [1:0] {
        DHBP_ENABLE = 2'h0,
        DHBP_STROBE = 2'h1,
        DHBP_SERIAL = 2'h2
    } dhbp_style_e;
    typedef enum logic [1:0] {
        DHBP_IDLE = 2'h0,
        DHBP_ACT = 2'h1,
        DHBP_END = 2'h2
    } dhbp_hstate_e;
endpackage

// ==== tb/dhbp_sva.sv ====
// Interface checks for the display host bus port
`timescale 1ns/1ps
`default_nettype none
module dhbp_sva (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic unit_select_low,
    input wire logic enable_or_read_strobe,
    input wire logic direction_or_write_strobe,
    input wire logic reset_input_low,
    input wire logic protocol_select_a,
    input wire logic protocol_select_b,
    input wire logic [7:0] host_data_out,
    input wire logic [7:0] host_data_oe,
    input wire logic dev_data_oe
);
    logic ena_sty;
    logic stb_sty;
    logic ser_sty;
    // Strap a is the low bit, matching the host MODE coding
    assign ser_sty = protocol_select_b;
    assign stb_sty = !protocol_select_b && protocol_select_a;
    assign ena_sty = !protocol_select_b && !protocol_select_a;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_enable_read_start: assert property (ena_sty && !unit_select_low &&
        direction_or_write_strobe && $rose(enable_or_read_strobe) |-> ##[1:3] dev_data_oe)
        else $error("enable read did not drive bus");
    a_enable_write_quiet: assert property (ena_sty && !unit_select_low &&
        !direction_or_write_strobe && $rose(enable_or_read_strobe) |-> !dev_data_oe [*4])
        else $error("bus driven during enable write");
    a_strobe_read_start: assert property (stb_sty && !unit_select_low &&
        $fell(enable_or_read_strobe) |-> ##[1:3] dev_data_oe)
        else $error("read strobe did not drive bus");
    a_strobe_write_quiet: assert property (stb_sty && !unit_select_low &&
        $fell(direction_or_write_strobe) |-> !dev_data_oe [*4])
        else $error("bus driven during strobe write");
    a_serial_strobes_grounded: assert property (ser_sty |->
        !enable_or_read_strobe && !direction_or_write_strobe)
        else $error("strobes not low in serial");
    a_no_bus_fight: assert property (dev_data_oe |-> host_data_oe == 8'h00)
        else $error("both ends drive the bus");
    a_serial_no_drive: assert property (ser_sty |-> !dev_data_oe)
        else $error("device drove bus in serial");
    a_spare_pins_low: assert property (ser_sty |-> !host_data_oe[2] &&
        (host_data_out[7:3] & host_data_oe[7:3]) == 5'h00)
        else $error("spare data pins not grounded");
    a_deselect_release: assert property ($rose(unit_select_low) |-> ##[0:2] !dev_data_oe)
        else $error("bus kept after deselect");
    a_reset_quiet: assert property (!reset_input_low |-> !dev_data_oe)
        else $error("bus driven in reset");
    a_oe_needs_read: assert property (dev_data_oe |-> (ena_sty ?
        ($past(enable_or_read_strobe) || $past(enable_or_read_strobe, 2)) :
        (!$past(enable_or_read_strobe) || !$past(enable_or_read_strobe, 2))))
        else $error("bus driven without read strobe");
    c_enable_read: cover property (ena_sty && $rose(dev_data_oe));
    c_strobe_read: cover property (stb_sty && $rose(dev_data_oe));
    c_serial_frame: cover property (ser_sty && $fell(unit_select_low));
endmodule
`default_nettype wire

// ==== tb/dhbp_tb_top.sv ====
// Self-checking bench joining host and device ends
`timescale 1ns/1ps
`default_nettype none
module dhbp_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic [1:0] mode = 2'h0;
    logic req = 1'b0;
    logic req_read = 1'b0;
    logic req_is_data = 1'b0;
    logic req_3wire = 1'b0;
    logic [7:0] req_byte = 8'h00;
    logic wr_valid, wr_is_data, rd_taken, rd_is_data, chip_reset, busy, done;
    logic [7:0] wr_byte, rd_byte;
    logic [1:0] style;
    int bad_count = 0;
    int compares = 0;
    int seed = 45224;
    int nwr = 0;
    int nrd = 0;
    always #2.5 clk = ~clk;
    dhbp_if bus ();
    dhbp_dev dhbp_dev_i (.CLK(clk), .RST_B(rst_b), .BUS(bus.dev), .RD_DATA(rd_data),
        .WR_VALID(wr_valid), .WR_BYTE(wr_byte), .WR_IS_DATA(wr_is_data), .RD_TAKEN(rd_taken),
        .RD_IS_DATA(rd_is_data), .STYLE(style), .CHIP_RESET(chip_reset));
    dhbp_host dhbp_host_i (.CLK(clk), .RST_B(rst_b), .BUS(bus.host), .MODE(mode), .REQ(req),
        .REQ_READ(req_read), .REQ_IS_DATA(req_is_data), .REQ_3WIRE(req_3wire),
        .REQ_BYTE(req_byte), .BUSY(busy), .DONE(done), .RD_BYTE(rd_byte));
    dhbp_sva dhbp_sva_i (.CLK(clk), .RST_B(rst_b), .unit_select_low(bus.unit_select_low),
        .enable_or_read_strobe(bus.enable_or_read_strobe),
        .direction_or_write_strobe(bus.direction_or_write_strobe),
        .reset_input_low(bus.reset_input_low), .protocol_select_a(bus.protocol_select_a),
        .protocol_select_b(bus.protocol_select_b), .host_data_out(bus.host_data_out),
        .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));
    // Pulse counters let one check catch lost and doubled transfers
    always @(posedge clk) begin
        if (wr_valid === 1'b1) nwr <= nwr + 1;
        if (rd_taken === 1'b1) nrd <= nrd + 1;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] exp_style(input logic [1:0] m);
        return m[1] ? 2'h2 : m;
    endfunction
    task automatic finish_test;
        $display("mismatches %0d of %0d compares", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] m);
        @(posedge clk);
        rst_b <= 1'b0;
        mode <= m;
        repeat (2) @(posedge clk);
        chk({7'h00, chip_reset}, 8'h01);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk({6'h00, style}, {6'h00, exp_style(m)});
    endtask
    task automatic xfer(input logic rd, input logic dc, input logic w3, input logic [7:0] b);
        int n;
        int w0;
        int r0;
        w0 = nwr;
        r0 = nrd;
        @(posedge clk);
        req <= 1'b1;
        req_read <= rd;
        req_is_data <= dc;
        req_3wire <= w3;
        req_byte <= b;
        rd_data <= b;
        for (n = 0; n < 50 && busy !== 1'b1; n++) @(posedge clk);
        req <= 1'b0;
        for (n = 0; n < 1000; n++) begin
            @(posedge clk);
            if (done === 1'b1) break;
        end
        if (n == 1000) chk(8'hEE, 8'h00);
        @(posedge clk);
        if (rd) begin
            chk(8'(nrd - r0), 8'h01);
            chk(rd_byte, b);
            chk({7'h00, rd_is_data}, {7'h00, dc});
        end else begin
            chk(8'(nwr - w0), 8'h01);
            chk(wr_byte, b);
            chk({7'h00, wr_is_data}, {7'h00, dc & ~w3});
        end
    endtask
    initial begin
        logic [1:0] m;
        for (int k = 0; k < 4; k++) begin
            m = 2'(k);
            do_reset(m);
            // Extreme bytes and both routes first, then back-to-back random
            xfer(1'b0, 1'b1, 1'b0, 8'hFF);
            xfer(1'b0, 1'b0, 1'b0, 8'h00);
            if (!m[1]) begin
                xfer(1'b1, 1'b1, 1'b0, 8'hA5);
                xfer(1'b1, 1'b0, 1'b0, 8'h5A);
            end
            repeat (8) begin
                xfer(!m[1] & 1'($random(seed)), 1'($random(seed)), m[1] & 1'($random(seed)),
                    8'($random(seed)));
            end
        end
        finish_test;
    end
    initial begin
        #200000;
        bad_count++;
        finish_test;
    end
endmodule
`default_nettype wire
